/* rtl/bus_sizing_pkg.sv */
package bus_sizing_pkg;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_START = 3'b010,
    ST_WAIT  = 3'b100
  } bus_state_t;

  // ----------------------------------------------------------------
  // geometry and reset values
  // ----------------------------------------------------------------
  localparam int unsigned BYTE_LANES = 4;
  localparam int unsigned LINE_WORDS = 4;
  localparam logic [1:0] LINE_LAST_WORD = 2'h3;
  localparam logic [3:0] ALL_LANES = 4'hF;
  localparam logic [3:0] NO_LANES = 4'h0;
  localparam logic [3:0] LOW_HALF = 4'h3;
  localparam logic [3:0] HIGH_HALF = 4'hC;
  localparam logic [7:0] ONE_BYTE_MASK = 8'h01;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;
  localparam logic [63:0] BUF_RESET = 64'h0000_0000_0000_0000;
  localparam logic [29:0] ADDR_RESET = 30'h0000_0000;
  localparam logic [29:0] WORD_STEP = 30'h0000_0001;
  localparam logic [1:0] FILL_STEP = 2'h1;

endpackage

/* rtl/cpu_bus_cycle_sizing.sv */
// Functional notes
// - narrow width during a line fill: as many 8/16-bit cycles as needed, up to 16
// - later fill cycles present lane enables for the bytes still needed
// - operand crossing a word on full bus: split, highest-order portion first
// - offsets 01/10/11: high part cycle then low part cycle
// - narrow width forcing extra cycles: low-order bytes or halves go first
// - 4-byte read at 16-bit width: low two bytes, then high two
// - 3-byte piece at 16-bit width: low half, upper byte, then remaining low byte; here two cycles: needed low-half lanes, then needed high-half lanes
// - 8-bit width: one byte per cycle, lowest byte first
// - every cycle is two clocks or more: strobe first clock, ready last
// - strobe asserted in the first clock with address and definition valid
// - ready sampled from the second clock on; ignored in the first
// - final-transfer flag low in the last cycle of a transfer
// - parity status driven one clock after a read ends; no internal action
`timescale 1ns/1ps
`default_nettype none

module cpu_bus_cycle_sizing (
  input wire logic clk,
  input wire logic reset_n,
  // user side
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic reqFill,
  input wire logic [31:0] reqAddr,
  input wire logic [2:0] reqSize,
  input wire logic [31:0] reqWriteData,
  output logic doneValid,
  output logic [31:0] doneData,
  // bus side
  output logic [29:0] wordAddr,
  output logic [3:0] byte_lane_enables_n,
  output logic cycle_start_strobe_n,
  output logic writeRead,
  output logic [31:0] dataOut,
  output logic dataOutEnN,
  input wire logic [31:0] dataIn,
  input wire logic [3:0] parityIn,
  input wire logic readyN,
  input wire logic burst_ready_n,
  input wire logic byte_width_request_n,
  input wire logic halfword_width_request_n,
  output logic final_transfer_flag_n,
  output logic parity_status_out_n
);

  // ----------------------------------------------------------------
  // lane selection for the present width
  // ----------------------------------------------------------------
  // lanes moved by one cycle; the low-order piece of what is left goes first
  function automatic logic [3:0] lanesTaken(input logic [3:0] need, input logic bs8n,
                                            input logic bs16n);
    logic [3:0] taken;
    taken = need;
    if (!bs8n) begin
      taken = need & (~need + 4'h1);
    end else if (!bs16n) begin
      taken = (|(need & bus_sizing_pkg::LOW_HALF)) ? (need & bus_sizing_pkg::LOW_HALF) :
              (need & bus_sizing_pkg::HIGH_HALF);
    end
    return taken;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  bus_sizing_pkg::bus_state_t state_reg, state_next;
  logic [29:0] wordAddr_reg, wordAddr_next;
  logic [3:0] need_reg, need_next;
  logic [3:0] pendLow_reg, pendLow_next;
  logic [1:0] fillLeft_reg, fillLeft_next;
  logic upperWord_reg, upperWord_next;
  logic write_reg, write_next;
  logic fill_reg, fill_next;
  logic [1:0] offset_reg, offset_next;
  logic [31:0] wdataHi_reg, wdataHi_next;
  logic [31:0] wdataLo_reg, wdataLo_next;
  logic [63:0] rbuf_reg, rbuf_next;
  logic doneValid_reg, doneValid_next;
  logic [31:0] doneData_reg, doneData_next;
  logic pchkArm_reg, pchkArm_next;
  logic pchkErr_reg;

  logic ready;
  logic [3:0] taken;
  logic [3:0] remain;
  logic lastPiece;
  logic parityErr;
  logic [7:0] opMask;
  logic [63:0] wideData;
  logic [63:0] shiftedBuf;

  // any ready term closes a simple cycle; burst ready acts as plain ready here
  assign ready = !readyN || !burst_ready_n;
  assign taken = lanesTaken(need_reg, byte_width_request_n, halfword_width_request_n);
  assign remain = need_reg & ~taken;
  assign lastPiece = (remain == bus_sizing_pkg::NO_LANES) &&
                     (pendLow_reg == bus_sizing_pkg::NO_LANES) &&
                     (fillLeft_reg == 2'h0);
  assign opMask = 8'((ONE_MASK(reqSize) - bus_sizing_pkg::ONE_BYTE_MASK) << reqAddr[1:0]);
  assign wideData = {32'h0000_0000, reqWriteData} << {reqAddr[1:0], 3'b000};

  function automatic logic [7:0] ONE_MASK(input logic [2:0] size);
    return 8'(bus_sizing_pkg::ONE_BYTE_MASK << size);
  endfunction

  lane_parity_check #(
    .LANES(bus_sizing_pkg::BYTE_LANES)
  ) u_parity (
    .data(dataIn),
    .parity(parityIn),
    .laneMask(taken),
    .error(parityErr)
  );

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    wordAddr_next = wordAddr_reg;
    need_next = need_reg;
    pendLow_next = pendLow_reg;
    fillLeft_next = fillLeft_reg;
    upperWord_next = upperWord_reg;
    write_next = write_reg;
    fill_next = fill_reg;
    offset_next = offset_reg;
    wdataHi_next = wdataHi_reg;
    wdataLo_next = wdataLo_reg;
    rbuf_next = rbuf_reg;
    doneValid_next = 1'b0;
    doneData_next = doneData_reg;
    pchkArm_next = 1'b0;
    shiftedBuf = BUF_ZERO();
    unique case (state_reg)
      bus_sizing_pkg::ST_IDLE: begin
        if (reqValid) begin
          state_next = bus_sizing_pkg::ST_START;
          write_next = reqWrite && !reqFill;
          fill_next = reqFill;
          offset_next = reqAddr[1:0];
          wdataHi_next = wideData[63:32];
          wdataLo_next = wideData[31:0];
          rbuf_next = bus_sizing_pkg::BUF_RESET;
          if (reqFill) begin
            wordAddr_next = {reqAddr[31:4], 2'b00};
            need_next = bus_sizing_pkg::ALL_LANES;
            pendLow_next = bus_sizing_pkg::NO_LANES;
            fillLeft_next = bus_sizing_pkg::LINE_LAST_WORD;
            upperWord_next = 1'b0;
          end else if (opMask[7:4] != bus_sizing_pkg::NO_LANES) begin
            // word-crossing operand: upper word goes out first
            wordAddr_next = reqAddr[31:2] + bus_sizing_pkg::WORD_STEP;
            need_next = opMask[7:4];
            pendLow_next = opMask[3:0];
            fillLeft_next = 2'h0;
            upperWord_next = 1'b1;
          end else begin
            wordAddr_next = reqAddr[31:2];
            need_next = opMask[3:0];
            pendLow_next = bus_sizing_pkg::NO_LANES;
            fillLeft_next = 2'h0;
            upperWord_next = 1'b0;
          end
        end
      end
      bus_sizing_pkg::ST_START: begin
        // ready is not looked at in the first clock
        state_next = bus_sizing_pkg::ST_WAIT;
      end
      bus_sizing_pkg::ST_WAIT: begin
        if (ready) begin
          for (int i = 0; i < 4; i++) begin
            if (taken[i]) begin
              rbuf_next[(upperWord_reg ? 32 : 0) + 8*i +: 8] = dataIn[8*i +: 8];
            end
          end
          pchkArm_next = !write_reg;
          if (remain != bus_sizing_pkg::NO_LANES) begin
            need_next = remain;
            state_next = bus_sizing_pkg::ST_START;
          end else if (pendLow_reg != bus_sizing_pkg::NO_LANES) begin
            need_next = pendLow_reg;
            pendLow_next = bus_sizing_pkg::NO_LANES;
            wordAddr_next = wordAddr_reg - bus_sizing_pkg::WORD_STEP;
            upperWord_next = 1'b0;
            state_next = bus_sizing_pkg::ST_START;
          end else begin
            if (fill_reg) begin
              // each finished line word is handed over on its own
              doneData_next = rbuf_next[31:0];
            end else begin
              shiftedBuf = rbuf_next >> {offset_reg, 3'b000};
              doneData_next = write_reg ? doneData_reg : shiftedBuf[31:0];
            end
            doneValid_next = 1'b1;
            if (fillLeft_reg != 2'h0) begin
              fillLeft_next = fillLeft_reg - bus_sizing_pkg::FILL_STEP;
              wordAddr_next = wordAddr_reg + bus_sizing_pkg::WORD_STEP;
              need_next = bus_sizing_pkg::ALL_LANES;
              rbuf_next = bus_sizing_pkg::BUF_RESET;
              state_next = bus_sizing_pkg::ST_START;
            end else begin
              need_next = bus_sizing_pkg::NO_LANES;
              state_next = bus_sizing_pkg::ST_IDLE;
            end
          end
        end
      end
    endcase
  end

  function automatic logic [63:0] BUF_ZERO();
    return bus_sizing_pkg::BUF_RESET;
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= bus_sizing_pkg::ST_IDLE;
      wordAddr_reg <= bus_sizing_pkg::ADDR_RESET;
      need_reg <= bus_sizing_pkg::NO_LANES;
      pendLow_reg <= bus_sizing_pkg::NO_LANES;
      fillLeft_reg <= 2'h0;
      upperWord_reg <= 1'b0;
      write_reg <= 1'b0;
      fill_reg <= 1'b0;
      offset_reg <= 2'h0;
      wdataHi_reg <= bus_sizing_pkg::DATA_RESET;
      wdataLo_reg <= bus_sizing_pkg::DATA_RESET;
      rbuf_reg <= bus_sizing_pkg::BUF_RESET;
      doneValid_reg <= 1'b0;
      doneData_reg <= bus_sizing_pkg::DATA_RESET;
      pchkArm_reg <= 1'b0;
      pchkErr_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      wordAddr_reg <= wordAddr_next;
      need_reg <= need_next;
      pendLow_reg <= pendLow_next;
      fillLeft_reg <= fillLeft_next;
      upperWord_reg <= upperWord_next;
      write_reg <= write_next;
      fill_reg <= fill_next;
      offset_reg <= offset_next;
      wdataHi_reg <= wdataHi_next;
      wdataLo_reg <= wdataLo_next;
      rbuf_reg <= rbuf_next;
      doneValid_reg <= doneValid_next;
      doneData_reg <= doneData_next;
      pchkArm_reg <= pchkArm_next;
      pchkErr_reg <= pchkArm_next && parityErr;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reqReady = (state_reg == bus_sizing_pkg::ST_IDLE);
  assign doneValid = doneValid_reg;
  assign doneData = doneData_reg;
  assign wordAddr = wordAddr_reg;
  assign byte_lane_enables_n = ~need_reg;
  assign cycle_start_strobe_n = (state_reg != bus_sizing_pkg::ST_START);
  assign writeRead = write_reg;
  assign dataOut = upperWord_reg ? wdataHi_reg : wdataLo_reg;
  assign dataOutEnN = !(write_reg && (state_reg != bus_sizing_pkg::ST_IDLE));
  // flag is not valid in the first clock, so it is held high there
  assign final_transfer_flag_n = !((state_reg == bus_sizing_pkg::ST_WAIT) && lastPiece);
  // status only leaves the block; nothing inside reacts to it
  assign parity_status_out_n = !(pchkArm_reg && pchkErr_reg);

endmodule

`default_nettype wire

/* rtl/lane_parity_check.sv */
`timescale 1ns/1ps
`default_nettype none

// even parity per byte lane; only lanes in laneMask can report an error
module lane_parity_check #(
  parameter int unsigned LANES = 4
) (
  input wire logic [8*LANES-1:0] data,
  input wire logic [LANES-1:0] parity,
  input wire logic [LANES-1:0] laneMask,
  output logic error
);

  logic [LANES-1:0] laneBad;

  // ----------------------------------------------------------------
  // per-lane check
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < LANES; i++) begin : g_lane
      assign laneBad[i] = laneMask[i] & ((^data[8*i +: 8]) ^ parity[i]);
    end
  endgenerate

  assign error = |laneBad;

endmodule

`default_nettype wire

/* sim/bus_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// far-side memory controller, non-burst only
// ----------------------------------------------------------------
module bus_ctrl_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cycle_start_strobe_n,
  input wire logic [29:0] wordAddr,
  input wire logic [1:0] mode,
  input wire logic [1:0] waits,
  input wire logic badParity,
  output logic readyN,
  output logic burst_ready_n,
  output logic byte_width_request_n,
  output logic halfword_width_request_n,
  output logic [31:0] dataIn,
  output logic [3:0] parityIn
);
  logic act;
  logic rdyReg;
  logic [1:0] cnt;
  logic [31:0] pat;
  always_ff @(posedge clk) begin
    if (!reset_n || (act && !rdyReg)) begin
      act <= 1'b0;
      rdyReg <= 1'b1;
    end else if (!cycle_start_strobe_n) begin
      act <= 1'b1;
      cnt <= waits;
      rdyReg <= waits != 2'h0;
    end else if (act) begin
      cnt <= cnt - 2'h1;
      rdyReg <= cnt > 2'h1;
    end
  end
  // waits of 3 also pulse ready in the strobe clock on purpose: the block must ignore it
  assign readyN = rdyReg && !(waits == 2'h3 && !cycle_start_strobe_n);
  assign burst_ready_n = 1'b1;
  // mode 0 is full-width memory
  assign byte_width_request_n = !(act && mode == 2'h2);
  assign halfword_width_request_n = !(act && mode == 2'h1);
  // all lanes carry their byte address whatever the enables; the whole bus and its parity invert outside a cycle
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pat[8*i+:8] = {wordAddr[5:0], 2'(i)};
      parityIn[i] = act ? ^pat[8*i+:8] ^ badParity : !(^pat[8*i+:8]);
    end
    dataIn = act ? pat : ~pat;
  end
endmodule
`default_nettype wire

/* sim/cpu_bus_cycle_sizing_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_cycle_sizing_sva (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic doneValid,
  input wire logic [29:0] wordAddr,
  input wire logic [3:0] byte_lane_enables_n,
  input wire logic cycle_start_strobe_n,
  input wire logic writeRead,
  input wire logic readyN,
  input wire logic final_transfer_flag_n,
  input wire logic parity_status_out_n
);
  // ----------------------------------------------------------------
  // bus cycle checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_take_strobe: assert property (reqValid && reqReady |=> !cycle_start_strobe_n)
    else $error("no strobe after take");
  chk_strobe_one: assert property (!cycle_start_strobe_n |=> cycle_start_strobe_n)
    else $error("strobe longer than one clock");
  chk_ready_ignore: assert property (!cycle_start_strobe_n && !readyN |=> !reqReady)
    else $error("ready taken in strobe clock");
  chk_addr_hold: assert property (!cycle_start_strobe_n |=>
    $stable(wordAddr) && $stable(byte_lane_enables_n))
    else $error("address moved in cycle");
  chk_final_first: assert property (!cycle_start_strobe_n |-> final_transfer_flag_n)
    else $error("final flag in first clock");
  chk_final_done: assert property (cycle_start_strobe_n && !reqReady && !readyN
    && !final_transfer_flag_n |=> doneValid && reqReady)
    else $error("last cycle did not finish");
  chk_more_pieces: assert property (cycle_start_strobe_n && !reqReady && !readyN
    && final_transfer_flag_n |=> !cycle_start_strobe_n)
    else $error("missing next cycle");
  chk_parity_time: assert property (!parity_status_out_n |->
    !$past(readyN) && !$past(writeRead) && !$past(reqReady) && $past(cycle_start_strobe_n))
    else $error("parity status off its clock");
  chk_idle_quiet: assert property (reqReady |->
    cycle_start_strobe_n && byte_lane_enables_n == 4'hF)
    else $error("idle bus not quiet");
endmodule
bind cpu_bus_cycle_sizing cpu_bus_cycle_sizing_sva u_sva (.clk, .reset_n, .reqValid,
  .reqReady, .doneValid, .wordAddr, .byte_lane_enables_n, .cycle_start_strobe_n,
  .writeRead, .readyN, .final_transfer_flag_n, .parity_status_out_n);
`default_nettype wire

/* sim/cpu_bus_cycle_sizing_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_cycle_sizing_tb_top;
  // ----------------------------------------------------------------
  // stimulus, far side and monitors
  // ----------------------------------------------------------------
  logic clk = 1'b0, reset_n = 1'b0, reqValid = 1'b0, reqWrite = 1'b0, reqFill = 1'b0;
  logic badParity = 1'b0;
  logic [31:0] reqAddr = 32'h0000_0000, reqWriteData = 32'h0000_BEEF;
  logic [2:0] reqSize = 3'h4;
  logic [1:0] mode = 2'h0, waits = 2'h0;
  logic reqReady, doneValid, writeRead, dataOutEnN, cycle_start_strobe_n, readyN;
  logic burst_ready_n, byte_width_request_n, halfword_width_request_n;
  logic final_transfer_flag_n, parity_status_out_n;
  logic [31:0] doneData, dataOut, dataIn, outSeen;
  logic [29:0] wordAddr;
  logic [3:0] byte_lane_enables_n, parityIn;
  logic [1:0] wrSeen;
  logic [5:0] laneLog[$];
  int num_errors = 0, tests_run = 0, pulses = 0, n = 0;
  initial forever #2.5 clk = ~clk;
  cpu_bus_cycle_sizing DUT (.clk, .reset_n, .reqValid, .reqReady, .reqWrite, .reqFill,
    .reqAddr, .reqSize, .reqWriteData, .doneValid, .doneData, .wordAddr, .byte_lane_enables_n,
    .cycle_start_strobe_n, .writeRead, .dataOut, .dataOutEnN, .dataIn, .parityIn, .readyN,
    .burst_ready_n, .byte_width_request_n, .halfword_width_request_n,
    .final_transfer_flag_n, .parity_status_out_n);
  bus_ctrl_model farSide (.clk, .reset_n, .cycle_start_strobe_n, .wordAddr, .mode, .waits,
    .badParity, .readyN, .burst_ready_n, .byte_width_request_n, .halfword_width_request_n,
    .dataIn, .parityIn);
  // sampled mid-clock, where the registered outputs have settled
  always @(negedge clk) begin
    if (reset_n && !cycle_start_strobe_n) begin
      laneLog.push_back({wordAddr[1:0], byte_lane_enables_n});
      outSeen = dataOut;
      wrSeen = {writeRead, dataOutEnN};
    end
    if (reset_n && !parity_status_out_n) pulses++;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // one whole transfer; ex lists {word bits, lane enables} of each strobe
  task automatic op(input logic w, f, input logic [31:0] a, input logic [2:0] sz,
      input logic [1:0] m, wt, input logic [5:0] ex[$]);
    int d;
    d = 0;
    n = 0;
    @(negedge clk);
    {mode, waits, reqWrite, reqFill, reqAddr, reqSize} = {m, wt, w, f, a, sz};
    laneLog.delete();
    pulses = 0;
    reqValid = 1'b1;
    @(negedge clk);
    reqValid = 1'b0;
    while (d < (f ? 4 : 1) && n < 200) begin
      @(negedge clk);
      n++;
      if (doneValid === 1'b1) d++;
    end
    @(negedge clk);
    chk("done count", f ? 4 : 1, d);
    chk("cycles", ex.size(), laneLog.size());
    foreach (ex[i]) chk("lanes", ex[i], laneLog[i]);
  endtask
  task automatic t_aligned();
    op(0, 0, 32'h0000_0010, 3'h4, 2'h0, 2'h0, '{6'h00});
    chk("latency", 2, n);
    chk("rdata", 32'h1312_1110, doneData);
    chk("read drive", 32'h0000_0001, wrSeen);
    $display("aligned done");
  endtask
  task automatic t_unaligned();
    logic [31:0] e;
    for (int k = 1; k < 4; k++) begin
      for (int i = 0; i < 4; i++) e[8*i+:8] = 8'(32 + k + i);
      op(0, 0, 32'(32 + k), 3'h4, 2'h0, 2'h1, '{{2'h1, 4'hF << k}, {2'h0, ~(4'hF << k)}});
      chk("rdata", e, doneData);
    end
    op(0, 0, 32'h0000_0027, 3'h2, 2'h0, 2'h0, '{6'h2E, 6'h17});
    chk("rdata", 32'h0000_2827, {16'h0000, doneData[15:0]});
    $display("unaligned done");
  endtask
  task automatic t_narrow();
    op(0, 0, 32'h0000_0030, 3'h4, 2'h1, 2'h1, '{6'h00, 6'h03});
    op(0, 0, 32'h0000_0033, 3'h4, 2'h1, 2'h0, '{6'h18, 6'h1B, 6'h07});
    chk("rdata", 32'h3635_3433, doneData);
    op(0, 0, 32'h0000_0040, 3'h4, 2'h2, 2'h0, '{6'h00, 6'h01, 6'h03, 6'h07});
    chk("rdata", 32'h4342_4140, doneData);
    $display("narrow done");
  endtask
  task automatic t_fill();
    logic [5:0] q[$];
    for (int m = 0; m < 3; m++) begin
      q.delete();
      for (int w = 0; w < 4; w++)
        for (int b = 0; b < 4; b += (m == 2) ? 1 : (m == 1) ? 2 : 4)
          q.push_back({2'(w), 4'(~(4'hF << b))});
      op(0, 1, 32'h0000_0058, 3'h4, 2'(m), 2'h0, q);
      chk("fill word", 32'h5F5E_5D5C, doneData);
    end
    $display("fill done");
  endtask
  task automatic t_write();
    op(1, 0, 32'h0000_0062, 3'h2, 2'h0, 2'h0, '{6'h03});
    chk("wdata", 32'h0000_BEEF, {16'h0000, outSeen[31:16]});
    chk("write drive", 32'h0000_0002, wrSeen);
    op(1, 0, 32'h0000_0060, 3'h2, 2'h2, 2'h1, '{6'h0C, 6'h0D});
    badParity = 1'b1;
    op(0, 0, 32'h0000_0010, 3'h4, 2'h0, 2'h2, '{6'h00});
    chk("parity_status_out_n read", 1, pulses);
    op(1, 0, 32'h0000_0010, 3'h4, 2'h0, 2'h3, '{6'h00});
    chk("parity_status_out_n write", 0, pulses);
    badParity = 1'b0;
    $display("write and parity done");
  endtask
  task automatic t_reset();
    @(negedge clk);
    {mode, waits, reqWrite, reqFill, reqAddr, reqValid} = {4'hB, 2'h0, 32'h0000_0021, 1'b1};
    @(negedge clk);
    reqValid = 1'b0;
    repeat (3) @(negedge clk);
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    chk("idle", 32'h0000_01FF, {reqReady, cycle_start_strobe_n, byte_lane_enables_n, dataOutEnN,
      final_transfer_flag_n, parity_status_out_n});
    reset_n = 1'b1;
    op(0, 0, 32'h0000_0010, 3'h4, 2'h0, 2'h0, '{6'h00});
    $display("reset done");
  endtask
  initial begin
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    t_aligned();
    t_unaligned();
    t_narrow();
    t_fill();
    t_write();
    t_reset();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    summarize();
  end
endmodule
`default_nettype wire
